// *** rtl/pdc_drive.sv ***
// Summary of operation
// - commands arrive on 0x200 plus node address
// - process data sent on 0x180 plus node
// - target reached flag set and cleared
// - control toggle copied into status bit 2
// - motor power bit tracks voltage window
// - release withdrawal abort flag, cleared by run/ack
// - running bit follows motor rotation
// - overtemperature flag with 5 degree hysteresis
// - against-loop flag set at reset, cleared on reach
// - fatal error bit cleared only by reset
// - blocked run flag and its clears
// - external displacement flag and its clears
// - bad target flag on out-of-limit targets
// - motor power missing flag at start/run
// - limit bits set beyond range, cleared inside
// - bits 0/1 request manual runs
// - target taken only with bit 2
// - release gates runs; dropping it aborts
// - bit 6 approaches targets without loop
// - readjust against loop needs bit 10
// - acknowledge edge clears error bits
`timescale 1ns/1ps
module pdc_drive
  import pdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [6:0] node_addr,
  input wire logic rx_valid,
  input wire logic [10:0] rx_id,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [10:0] tx_id,
  output logic [63:0] tx_data,
  input wire logic signed [31:0] actual_position,
  input wire logic [15:0] present_speed,
  input wire logic [15:0] motor_voltage,
  input wire logic [15:0] motor_voltage_threshold,
  input wire logic signed [15:0] temperature,
  input wire logic signed [15:0] temp_limit,
  input wire logic signed [31:0] upper_limit,
  input wire logic signed [31:0] lower_limit,
  input wire logic signed [31:0] loop_length,
  input wire logic [31:0] pos_window,
  input wire logic rotating,
  input wire logic run_reverse,
  input wire logic pos_done,
  input wire logic ref_loop_done,
  input wire logic overload_abort,
  input wire logic ext_rotation,
  input wire logic ext_rot_neg,
  input wire logic flash_fault,
  input wire logic calc_fault,
  output logic run_start,
  output logic run_abort,
  output logic release_on,
  output logic manual_up,
  output logic manual_down,
  output logic direct_approach,
  output logic readjust_enable,
  output logic [31:0] target_position,
  output logic [15:0] command_word,
  output logic [15:0] drive_status_word
);

  typedef struct packed {
    pdc_run_type run;
    logic [15:0] status;
    logic [15:0] cw;
    logic ack_prev;
    logic [31:0] target;
    logic tgt_valid;
    logic start;
    logic abort;
    logic tx_req;
  } pdc_drive_state_type;

  pdc_drive_state_type s;
  pdc_drive_state_type next_s;

  logic cw_valid;
  logic [15:0] cw;
  logic [31:0] cw_target;
  logic pwr_ok;
  logic ack_edge;
  logic tgt_ok;
  logic loop_on;
  logic manual_req;
  logic pos_req;
  logic opposite;
  logic [31:0] run_target;
  logic signed [31:0] loop_end;
  logic signed [15:0] temp_clear;

  // ************************************************************
  // frame ends
  // ************************************************************
  pdc_rx_decode u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .node_addr(node_addr),
    .rx_valid(rx_valid),
    .rx_id(rx_id),
    .rx_dlc(rx_dlc),
    .rx_data(rx_data),
    .cw_valid(cw_valid),
    .cw(cw),
    .cw_target(cw_target)
  );

  pdc_tx_encode u_tx (
    .clk(clk),
    .rst_n(rst_n),
    .node_addr(node_addr),
    .send_req(s.tx_req),
    .status(s.status),
    .speed(present_speed),
    .actual(actual_position),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_id(tx_id),
    .tx_data(tx_data)
  );

  // ************************************************************
  // status and run control
  // ************************************************************
  always_comb begin
    next_s = s;
    next_s.start = 1'b0;
    next_s.abort = 1'b0;
    ack_edge = 1'b0;
    manual_req = 1'b0;
    pos_req = 1'b0;
    run_target = s.target;
    pwr_ok = (motor_voltage > motor_voltage_threshold) && (motor_voltage < PDC_VMAX_MV);
    temp_clear = 16'(temp_limit - PDC_TEMP_HYST_C);
    loop_on = !cw[PDC_CW_NO_LOOP] && (loop_length != 32'sh0);
    loop_end = 32'(signed'(cw_target) - loop_length);
    tgt_ok = pdc_within(signed'(cw_target), lower_limit, upper_limit)
             && (!loop_on || pdc_within(loop_end, lower_limit, upper_limit));
    opposite = (loop_length >= 32'sh0) ? ext_rot_neg : !ext_rot_neg;

    // level-driven bits
    next_s.status[PDC_ST_POWER] = pwr_ok;
    next_s.status[PDC_ST_RUNNING] = rotating;
    if (temperature <= temp_clear) begin
      next_s.status[PDC_ST_HOT] = 1'b0;
    end
    if (temperature > temp_limit) begin
      next_s.status[PDC_ST_HOT] = 1'b1;
    end
    if (actual_position > lower_limit && actual_position < upper_limit) begin
      next_s.status[PDC_ST_LIMIT_FWD] = 1'b0;
      next_s.status[PDC_ST_LIMIT_REV] = 1'b0;
    end

    // received command word
    if (cw_valid) begin
      next_s.cw = cw;
      ack_edge = cw[PDC_CW_ACK] && !s.ack_prev;
      next_s.ack_prev = cw[PDC_CW_ACK];
      next_s.status[PDC_ST_TOGGLE] = cw[PDC_CW_TOGGLE];
      if (ack_edge) begin
        next_s.status[PDC_ST_RSVD1] = 1'b0;
        next_s.status[PDC_ST_ABORTED] = 1'b0;
        next_s.status[PDC_ST_BLOCKED] = 1'b0;
        next_s.status[PDC_ST_DISPLACED] = 1'b0;
        next_s.status[PDC_ST_BAD_TARGET] = 1'b0;
        next_s.status[PDC_ST_POWER_LOST] = 1'b0;
      end
      if (cw[PDC_CW_TAKE_TARGET]) begin
        if (tgt_ok) begin
          next_s.target = cw_target;
          next_s.tgt_valid = 1'b1;
          next_s.status[PDC_ST_BAD_TARGET] = 1'b0;
          run_target = cw_target;
        end else begin
          next_s.status[PDC_ST_BAD_TARGET] = 1'b1;
          next_s.status[PDC_ST_REACHED] = 1'b0;
        end
      end
      case (s.run)
        PDC_IDLE: begin
          // fatal error refuses every run command
          if (cw[PDC_CW_RELEASE] && !s.status[PDC_ST_FATAL]) begin
            manual_req = cw[PDC_CW_MAN_UP] ^ cw[PDC_CW_MAN_DOWN];
            pos_req = !manual_req && (cw[PDC_CW_TAKE_TARGET] ? tgt_ok
                      : (!s.cw[PDC_CW_RELEASE] && s.tgt_valid));
          end
        end
        PDC_POS: begin
          if (!cw[PDC_CW_RELEASE]) begin
            next_s.run = PDC_IDLE;
            next_s.abort = 1'b1;
            next_s.status[PDC_ST_ABORTED] = 1'b1;
          end
        end
        PDC_MAN: begin
          if (!cw[PDC_CW_RELEASE]) begin
            next_s.run = PDC_IDLE;
            next_s.abort = 1'b1;
            next_s.status[PDC_ST_ABORTED] = 1'b1;
          end else if (!(cw[PDC_CW_MAN_UP] ^ cw[PDC_CW_MAN_DOWN])) begin
            next_s.run = PDC_IDLE;
            next_s.abort = 1'b1;
          end
        end
        default: begin
          next_s.run = PDC_IDLE;
        end
      endcase
    end

    // manual rotation at standstill, with optional readjustment
    if (ext_rotation && s.run == PDC_IDLE) begin
      next_s.status[PDC_ST_DISPLACED] = 1'b1;
      next_s.status[PDC_ST_REACHED] = 1'b0;
      if (s.cw[PDC_CW_RELEASE] && s.cw[PDC_CW_READJUST] && s.tgt_valid
          && !s.status[PDC_ST_FATAL]
          && (opposite || loop_length == 32'sh0)) begin
        if (pwr_ok) begin
          next_s.run = PDC_POS;
          next_s.start = 1'b1;
        end else begin
          next_s.status[PDC_ST_BLOCKED] = 1'b1;
          next_s.status[PDC_ST_POWER_LOST] = 1'b1;
        end
      end
    end

    // new run commands
    if (manual_req) begin
      next_s.run = PDC_MAN;
      next_s.start = 1'b1;
      next_s.status[PDC_ST_REACHED] = 1'b0;
      next_s.status[PDC_ST_ABORTED] = 1'b0;
    end
    if (pos_req) begin
      next_s.status[PDC_ST_ABORTED] = 1'b0;
      if (pwr_ok) begin
        next_s.run = PDC_POS;
        next_s.start = 1'b1;
        next_s.status[PDC_ST_POWER_LOST] = 1'b0;
        next_s.status[PDC_ST_BLOCKED] = 1'b0;
        next_s.status[PDC_ST_DISPLACED] = 1'b0;
        if (pdc_absdiff(signed'(run_target), actual_position) > pos_window) begin
          next_s.status[PDC_ST_REACHED] = 1'b0;
        end
      end else begin
        next_s.status[PDC_ST_POWER_LOST] = 1'b1;
      end
    end

    // motion-side events
    if (ref_loop_done) begin
      next_s.status[PDC_ST_AGAINST_LOOP] = 1'b0;
      next_s.status[PDC_ST_BLOCKED] = 1'b0;
      next_s.status[PDC_ST_DISPLACED] = 1'b0;
      if (actual_position == signed'(s.target)) begin
        next_s.status[PDC_ST_REACHED] = 1'b1;
      end
    end
    if (pos_done && s.run == PDC_POS) begin
      next_s.run = PDC_IDLE;
      next_s.status[PDC_ST_REACHED] = 1'b1;
      next_s.status[PDC_ST_AGAINST_LOOP] = 1'b0;
    end
    if (overload_abort && s.run != PDC_IDLE) begin
      next_s.run = PDC_IDLE;
      next_s.abort = 1'b1;
      next_s.status[PDC_ST_BLOCKED] = 1'b1;
    end
    if (s.run != PDC_IDLE && !pwr_ok) begin
      next_s.status[PDC_ST_POWER_LOST] = 1'b1;
    end
    if (rotating && (run_reverse == (loop_length >= 32'sh0))) begin
      next_s.status[PDC_ST_AGAINST_LOOP] = 1'b1;
    end
    if (flash_fault || calc_fault) begin
      next_s.status[PDC_ST_FATAL] = 1'b1;
    end
    if (actual_position > upper_limit
        || (s.run == PDC_MAN && manual_up && actual_position >= upper_limit)) begin
      next_s.status[PDC_ST_LIMIT_FWD] = 1'b1;
    end
    if (actual_position < lower_limit
        || (s.run == PDC_MAN && manual_down && actual_position <= lower_limit)) begin
      next_s.status[PDC_ST_LIMIT_REV] = 1'b1;
    end

    // answer each command word and every status change
    next_s.tx_req = cw_valid || (next_s.status != s.status);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{run: PDC_IDLE, status: PDC_STATUS_RESET, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // outputs to the motion core
  // ************************************************************
  assign run_start = s.start;
  assign run_abort = s.abort;
  assign release_on = s.cw[PDC_CW_RELEASE];
  assign manual_up = (s.run == PDC_MAN) && s.cw[PDC_CW_MAN_UP];
  assign manual_down = (s.run == PDC_MAN) && s.cw[PDC_CW_MAN_DOWN];
  assign direct_approach = s.cw[PDC_CW_NO_LOOP] || (loop_length == 32'sh0);
  assign readjust_enable = s.cw[PDC_CW_READJUST];
  assign target_position = s.target;
  assign command_word = s.cw;
  assign drive_status_word = s.status;

endmodule : pdc_drive

// *** shared/pdc_pkg.sv ***
package pdc_pkg;

  // ************************************************************
  // frame identifiers
  // ************************************************************
  localparam logic [10:0] PDC_RX_BASE_ID = 11'h200;
  localparam logic [10:0] PDC_TX_BASE_ID = 11'h180;
  localparam logic [3:0] PDC_FRAME_LEN = 4'h8;

  // ************************************************************
  // object indices of the process-data fields
  // ************************************************************
  localparam logic [15:0] PDC_IDX_TARGET_POSITION = 16'h2001;
  localparam logic [15:0] PDC_IDX_ACTUAL_POSITION = 16'h2003;
  localparam logic [15:0] PDC_IDX_COMMAND_WORD = 16'h2024;
  localparam logic [15:0] PDC_IDX_DRIVE_STATUS_WORD = 16'h2025;
  localparam logic [15:0] PDC_IDX_PRESENT_SPEED = 16'h2030;

  // ************************************************************
  // command word bits
  // ************************************************************
  localparam int PDC_CW_MAN_UP = 0;
  localparam int PDC_CW_MAN_DOWN = 1;
  localparam int PDC_CW_TAKE_TARGET = 2;
  localparam int PDC_CW_RELEASE = 4;
  localparam int PDC_CW_NO_LOOP = 6;
  localparam int PDC_CW_READJUST = 10;
  localparam int PDC_CW_TOGGLE = 13;
  localparam int PDC_CW_ACK = 14;

  // ************************************************************
  // status word bits
  // ************************************************************
  localparam int PDC_ST_REACHED = 0;
  localparam int PDC_ST_RSVD1 = 1;
  localparam int PDC_ST_TOGGLE = 2;
  localparam int PDC_ST_POWER = 4;
  localparam int PDC_ST_ABORTED = 5;
  localparam int PDC_ST_RUNNING = 6;
  localparam int PDC_ST_HOT = 7;
  localparam int PDC_ST_AGAINST_LOOP = 8;
  localparam int PDC_ST_FATAL = 9;
  localparam int PDC_ST_BLOCKED = 10;
  localparam int PDC_ST_DISPLACED = 11;
  localparam int PDC_ST_BAD_TARGET = 12;
  localparam int PDC_ST_POWER_LOST = 13;
  localparam int PDC_ST_LIMIT_FWD = 14;
  localparam int PDC_ST_LIMIT_REV = 15;
  localparam logic [15:0] PDC_STATUS_RESET = 16'h0100;

  // ************************************************************
  // analog thresholds
  // ************************************************************
  localparam logic [15:0] PDC_VMAX_MV = 16'h7530;
  localparam logic signed [15:0] PDC_TEMP_HYST_C = 16'sh0005;

  // ************************************************************
  // run state
  // ************************************************************
  typedef enum logic [2:0] {
    PDC_IDLE = 3'b001,
    PDC_POS = 3'b010,
    PDC_MAN = 3'b100
  } pdc_run_type;

  function automatic logic pdc_within(input logic signed [31:0] v,
                                      input logic signed [31:0] lo,
                                      input logic signed [31:0] hi);
    pdc_within = (v >= lo) && (v <= hi);
  endfunction : pdc_within

  function automatic logic [31:0] pdc_absdiff(input logic signed [31:0] a,
                                              input logic signed [31:0] b);
    pdc_absdiff = (a > b) ? 32'(a - b) : 32'(b - a);
  endfunction : pdc_absdiff

endpackage : pdc_pkg

// *** rtl/pdc_rx_decode.sv ***
`timescale 1ns/1ps
module pdc_rx_decode
  import pdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [6:0] node_addr,
  input wire logic rx_valid,
  input wire logic [10:0] rx_id,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  output logic cw_valid,
  output logic [15:0] cw,
  output logic [31:0] cw_target
);

  typedef struct packed {
    logic valid;
    logic [15:0] cw;
    logic [31:0] target;
  } pdc_rx_state_type;

  pdc_rx_state_type s;
  pdc_rx_state_type next_s;
  logic hit;

  // ************************************************************
  // frame filter and unpack
  // ************************************************************
  always_comb begin
    next_s = s;
    next_s.valid = 1'b0;
    hit = rx_valid && (rx_id == PDC_RX_BASE_ID + {4'h0, node_addr})
          && (rx_dlc == PDC_FRAME_LEN);
    if (hit) begin
      next_s.valid = 1'b1;
      next_s.cw = rx_data[15:0];
      next_s.target = rx_data[63:32];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cw_valid = s.valid;
  assign cw = s.cw;
  assign cw_target = s.target;

endmodule : pdc_rx_decode

// *** rtl/pdc_tx_encode.sv ***
`timescale 1ns/1ps
module pdc_tx_encode
  import pdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [6:0] node_addr,
  input wire logic send_req,
  input wire logic [15:0] status,
  input wire logic [15:0] speed,
  input wire logic [31:0] actual,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [10:0] tx_id,
  output logic [63:0] tx_data
);

  typedef struct packed {
    logic busy;
    logic pending;
    logic [10:0] id;
    logic [63:0] data;
  } pdc_tx_state_type;

  pdc_tx_state_type s;
  pdc_tx_state_type next_s;

  // ************************************************************
  // frame latch, one request kept while busy
  // ************************************************************
  always_comb begin
    next_s = s;
    if (s.busy && tx_ready) begin
      next_s.busy = 1'b0;
    end
    if (send_req && s.busy) begin
      next_s.pending = 1'b1;
    end
    if (!next_s.busy && (send_req || s.pending)) begin
      next_s.busy = 1'b1;
      next_s.pending = 1'b0;
      next_s.id = PDC_TX_BASE_ID + {4'h0, node_addr};
      next_s.data = {actual, speed, status};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tx_valid = s.busy;
  assign tx_id = s.id;
  assign tx_data = s.data;

endmodule : pdc_tx_encode

// *** tb/pdc_host_model.sv ***
`timescale 1ns/1ps
module pdc_host_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [10:0] tx_id,
  input wire logic [63:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [10:0] rx_id,
  output logic [3:0] rx_dlc,
  output logic [63:0] rx_data
);
  logic [63:0] frm = 64'h0;
  logic [63:0] scr = 64'h5A5A_0F0F_3C3C_9669;
  logic [63:0] got_q[$];
  logic [10:0] id_q[$];
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_id = 11'h000;
    rx_dlc = 4'h0;
  end
  // idle payload scrambled so stale bytes never look valid
  assign rx_data = rx_valid ? frm : scr;
  always @(posedge clk) begin
    scr <= ~scr;
    tx_ready <= !stall && ($urandom % 4 != 0);
    if (tx_valid && tx_ready) begin
      got_q.push_back(tx_data);
      id_q.push_back(tx_id);
    end
  end
  task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [15:0] cw,
                      input logic [31:0] tgt, input logic hold);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_dlc <= dlc;
    frm <= {tgt, 16'hA5C3, cw & 16'h6457};
    @(posedge clk);
    if (!hold) rx_valid <= 1'b0;
  endtask : send
endmodule : pdc_host_model

// *** tb/pdc_drive_assertions.sv ***
`timescale 1ns/1ps
module pdc_drive_assertions
  import pdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [6:0] node_addr,
  input wire logic rx_valid,
  input wire logic [10:0] rx_id,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [10:0] tx_id,
  input wire logic [63:0] tx_data,
  input wire logic [15:0] motor_voltage,
  input wire logic [15:0] motor_voltage_threshold,
  input wire logic run_start,
  input wire logic release_on,
  input wire logic manual_up,
  input wire logic manual_down,
  input wire logic [31:0] target_position,
  input wire logic [15:0] command_word,
  input wire logic [15:0] drive_status_word
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_taken;
    rx_valid && rx_id == PDC_RX_BASE_ID + 11'(node_addr) && rx_dlc == PDC_FRAME_LEN;
  endsequence
  sequence s_take_target;
    s_taken ##0 rx_data[PDC_CW_TAKE_TARGET];
  endsequence
  a_cmd_capture: assert property (s_taken |-> ##2 command_word == $past(rx_data[15:0], 2))
    else $error("command word not captured");
  a_target_take: assert property (
    s_take_target |-> ##2 (drive_status_word[PDC_ST_BAD_TARGET] ? $stable(target_position)
      : target_position == $past(rx_data[63:32], 2)))
    else $error("target not taken");
  a_toggle_echo: assert property (
    s_taken |-> ##2 drive_status_word[PDC_ST_TOGGLE] == $past(rx_data[13], 2))
    else $error("toggle not echoed");
  a_release_gate: assert property (s_taken |-> ##2 release_on == $past(rx_data[4], 2))
    else $error("release not followed");
  a_tx_ident: assert property (tx_valid |-> tx_id == PDC_TX_BASE_ID + 11'(node_addr))
    else $error("transmit identifier wrong");
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_id))
    else $error("transmit frame dropped early");
  a_tx_follows: assert property (s_taken |-> ##[1:4] tx_valid)
    else $error("no transmit after command");
  a_power_window: assert property ($past(rst_n) |-> drive_status_word[PDC_ST_POWER] ==
    $past(motor_voltage > motor_voltage_threshold && motor_voltage < PDC_VMAX_MV))
    else $error("power bit wrong");
  a_fatal_sticky: assert property (drive_status_word[PDC_ST_FATAL] |=>
    drive_status_word[PDC_ST_FATAL])
    else $error("fatal bit cleared");
  a_fatal_refuse: assert property (
    drive_status_word[PDC_ST_FATAL] && $past(drive_status_word[PDC_ST_FATAL]) |-> !run_start)
    else $error("run started while fatal");
  a_manual_excl: assert property (!(manual_up && manual_down))
    else $error("both manual directions");
endmodule : pdc_drive_assertions
bind pdc_drive pdc_drive_assertions u_chk (.clk, .rst_n, .node_addr, .rx_valid, .rx_id,
  .rx_dlc, .rx_data, .tx_ready, .tx_valid, .tx_id, .tx_data, .motor_voltage,
  .motor_voltage_threshold, .run_start, .release_on, .manual_up, .manual_down,
  .target_position, .command_word, .drive_status_word);

// *** tb/drive_process_data_control_status_test.sv ***
`timescale 1ns/1ps
module drive_process_data_control_status_test;
  import pdc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic stall = 1'b0;
  logic [6:0] node_addr = 7'h01;
  logic rx_valid, tx_ready, tx_valid, run_start, run_abort, release_on;
  logic manual_up, manual_down, direct_approach, readjust_enable;
  logic [10:0] rx_id, tx_id;
  logic [3:0] rx_dlc;
  logic [63:0] rx_data, tx_data;
  logic [31:0] target_position;
  logic [15:0] command_word, drive_status_word;
  logic signed [31:0] actual_position = 32'sh0000_1234;
  logic signed [31:0] upper_limit = 32'sh0001_86A0;
  logic signed [31:0] lower_limit = -32'sh0001_86A0;
  logic signed [31:0] loop_length = 32'sh0;
  logic [31:0] pos_window = 32'h0000_000A;
  logic [15:0] present_speed = 16'h0321;
  logic [15:0] motor_voltage = 16'h5DC0;
  logic [15:0] motor_voltage_threshold = 16'h2EE0;
  logic signed [15:0] temperature = 16'sh0019;
  logic signed [15:0] temp_limit = 16'sh0046;
  logic rotating = 1'b0, run_reverse = 1'b0, pos_done = 1'b0, ref_loop_done = 1'b0;
  logic overload_abort = 1'b0, ext_rotation = 1'b0, ext_rot_neg = 1'b0;
  logic flash_fault = 1'b0, calc_fault = 1'b0;
  int err_count = 0, check_count = 0, cyc = 0, starts = 0, aborts = 0;
  logic [15:0] m_cw = 16'h0;
  logic [31:0] m_tgt = 32'h0;
  logic hot = 1'b0;
  logic [15:0] volts[6] = '{16'h2EDF, 16'h2EE0, 16'h2EE1, 16'h752F, 16'h7530, 16'h7531};
  logic signed [15:0] temps[5] = '{16'sh47, 16'sh44, 16'sh42, 16'sh41, 16'sh45};

  pdc_drive dut (.clk, .rst_n, .node_addr, .rx_valid, .rx_id, .rx_dlc, .rx_data, .tx_ready,
    .tx_valid, .tx_id, .tx_data, .actual_position, .present_speed, .motor_voltage,
    .motor_voltage_threshold, .temperature, .temp_limit, .upper_limit, .lower_limit,
    .loop_length, .pos_window, .rotating, .run_reverse, .pos_done, .ref_loop_done,
    .overload_abort, .ext_rotation, .ext_rot_neg, .flash_fault, .calc_fault, .run_start,
    .run_abort, .release_on, .manual_up, .manual_down, .direct_approach, .readjust_enable,
    .target_position, .command_word, .drive_status_word);
  pdc_host_model u_host (.clk, .stall, .tx_valid, .tx_id, .tx_data, .tx_ready, .rx_valid,
    .rx_id, .rx_dlc, .rx_data);

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (run_start === 1'b1) starts++;
    if (run_abort === 1'b1) aborts++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic st(input string what, input int b, input logic e);
    settle();
    chk(what, 64'(drive_status_word[b]), 64'(e));
  endtask : st
  task automatic frame(input logic [15:0] cw, input logic [31:0] tgt);
    int t;
    t = tgt;
    u_host.send(PDC_RX_BASE_ID + 11'(node_addr), 4'h8, cw, tgt, 1'b0);
    m_cw = cw & 16'h6457;
    if (m_cw[2] && t >= lower_limit && t <= upper_limit
        && (m_cw[6] || loop_length == 0
        || (t - loop_length >= lower_limit && t - loop_length <= upper_limit))) begin
      m_tgt = tgt;
    end
    repeat (2) @(posedge clk);
    #1;
    chk("command_word", 64'(command_word), 64'(m_cw));
    chk("target", 64'(target_position), 64'(m_tgt));
    chk("toggle", 64'(drive_status_word[2]), 64'(m_cw[13]));
    chk("release", 64'(release_on), 64'(m_cw[4]));
    chk("direct", 64'(direct_approach), 64'(m_cw[6] || loop_length == 0));
    chk("readjust", 64'(readjust_enable), 64'(m_cw[10]));
  endtask : frame
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    void'($urandom(32'h5724));
    node_addr = 7'($urandom_range(127, 1));
    repeat (4) @(posedge clk);
    #1;
    chk("reset status", 64'(drive_status_word), 64'h0100);
    chk("reset tx", 64'(tx_valid), 64'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    u_host.send(PDC_RX_BASE_ID + 11'(node_addr) + 11'h1, 4'h8, 16'h0014, 32'h77, 1'b0);
    u_host.send(PDC_RX_BASE_ID + 11'(node_addr), 4'h7, 16'h0014, 32'h77, 1'b0);
    settle();
    chk("foreign frame", 64'(command_word), 64'h0);
    frame(16'h0014, 32'h0000_04D2);
    settle();
    chk("starts", 64'(starts), 64'h1);
    frame(16'h0000, 32'h0);
    st("aborted", PDC_ST_ABORTED, 1'b1);
    chk("aborts", 64'(aborts), 64'h1);
    frame(16'h4000, 32'h0);
    st("ack aborted", PDC_ST_ABORTED, 1'b0);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      loop_length <= ($urandom % 2) ? 32'sh64 : 32'sh0;
      frame(16'($urandom) & 16'hBFEF, $urandom);
    end
    @(posedge clk);
    loop_length <= 32'sh0;
    u_host.got_q.delete();
    stall <= 1'b1;
    frame(16'h2000, 32'h0);
    repeat (10) @(posedge clk);
    #1;
    chk("tx stands", 64'(tx_valid), 64'h1);
    chk("tx id", 64'(tx_id), 64'(PDC_TX_BASE_ID + 11'(node_addr)));
    stall <= 1'b0;
    for (int i = 0; i < 60 && tx_valid !== 1'b0; i++) @(posedge clk);
    #1;
    chk("tx frame", u_host.got_q[$], {actual_position, present_speed, drive_status_word});
    foreach (volts[i]) begin
      @(posedge clk);
      motor_voltage <= volts[i];
      st("power", PDC_ST_POWER, volts[i] > 16'h2EE0 && volts[i] < 16'h7530);
    end
    @(posedge clk);
    motor_voltage <= 16'h5DC0;
    foreach (temps[i]) begin
      @(posedge clk);
      temperature <= temps[i];
      hot = (temps[i] > 16'sh46) ? 1'b1 : (temps[i] <= 16'sh41) ? 1'b0 : hot;
      st("hot", PDC_ST_HOT, hot);
    end
    @(posedge clk);
    rotating <= 1'b1;
    st("running", PDC_ST_RUNNING, 1'b1);
    @(posedge clk);
    rotating <= 1'b0;
    st("standstill", PDC_ST_RUNNING, 1'b0);
    frame(16'h0004, 32'h0003_0D40);
    st("bad target", PDC_ST_BAD_TARGET, 1'b1);
    frame(16'h0000, 32'h0);
    frame(16'h4000, 32'h0);
    st("ack bad target", PDC_ST_BAD_TARGET, 1'b0);
    frame(16'h0414, 32'h0000_0032);
    @(posedge clk);
    pos_done <= 1'b1;
    @(posedge clk);
    pos_done <= 1'b0;
    st("reached", PDC_ST_REACHED, 1'b1);
    frame(16'h0011, 32'h0);
    chk("manual dirs", 64'({manual_up, manual_down}), 64'h2);
    st("manual reach", PDC_ST_REACHED, 1'b0);
    frame(16'h0010, 32'h0);
    chk("manual end", 64'({manual_up, manual_down}), 64'h0);
    frame(16'h0014, 32'h0000_0050);
    @(posedge clk);
    overload_abort <= 1'b1;
    @(posedge clk);
    overload_abort <= 1'b0;
    ext_rotation <= 1'b1;
    @(posedge clk);
    ext_rotation <= 1'b0;
    actual_position <= 32'sh0001_86A1;
    st("blocked", PDC_ST_BLOCKED, 1'b1);
    chk("displaced", 64'(drive_status_word[PDC_ST_DISPLACED]), 64'h1);
    chk("limit fwd", 64'(drive_status_word[PDC_ST_LIMIT_FWD]), 64'h1);
    @(posedge clk);
    actual_position <= 32'sh0000_1234;
    st("limit cleared", PDC_ST_LIMIT_FWD, 1'b0);
    @(posedge clk);
    flash_fault <= 1'b1;
    @(posedge clk);
    flash_fault <= 1'b0;
    st("fatal", PDC_ST_FATAL, 1'b1);
    starts = 0;
    frame(16'h0000, 32'h0);
    frame(16'h0014, 32'h0000_0040);
    st("fatal held", PDC_ST_FATAL, 1'b1);
    chk("no run when fatal", 64'(starts), 64'h0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    m_cw = 16'h0;
    m_tgt = 32'h0;
    st("fatal cleared", PDC_ST_FATAL, 1'b0);
    chk("loop flag", 64'(drive_status_word[PDC_ST_AGAINST_LOOP]), 64'h1);
    frame(16'h2014, 32'h0000_0010);
    tally_and_finish();
  end
endmodule : drive_process_data_control_status_test
